// file: src/sqd_pkg.sv
package sqd_pkg;
    localparam int NUM_CH = 8;
    localparam int CLK_NS = 25;
    // ****************************************
    // serial frame: wr, addr, data, 00, odd parity
    // ****************************************
    localparam int FRAME_W = 16;
    localparam int F_WR = 15;
    localparam int F_ADDR_LO = 11;
    localparam int F_DATA_LO = 3;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    // ****************************************
    // device register addresses
    // ****************************************
    localparam logic [3:0] A_CFG = 4'h0;
    localparam logic [3:0] A_KEY = 4'h1;
    localparam logic [3:0] A_HS_ON = 4'h2;
    localparam logic [3:0] A_LS_ON = 4'h3;
    localparam logic [3:0] A_LS_OFF = 4'h4;
    localparam logic [3:0] A_STATUS = 4'h5;
    localparam logic [3:0] A_EXPIRED = 4'h6;
    localparam logic [3:0] A_THERMAL = 4'h7;
    localparam logic [3:0] A_ONTIME0 = 4'h8;
    localparam int CFG_HS_HIGH = 0;
    localparam int CFG_LS_HW = 1;
    localparam logic [7:0] ARM_KEY = 8'hA5;
    localparam logic [7:0] ONTIME_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h02;
    // ****************************************
    // timing
    // ****************************************
    localparam int ONTIME_STEP_NS = 32160;
    localparam int STEP_CYC = ONTIME_STEP_NS / CLK_NS;
    localparam int LS_OFF_DELAY_NS = 100000;
    localparam int LS_OFF_CYC = LS_OFF_DELAY_NS / CLK_NS;
    localparam int SCLK_HALF_NS = 100;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;
    // ****************************************
    // controller apb map
    // ****************************************
    localparam logic [7:0] H_CMD = 8'h00;
    localparam logic [7:0] H_RESP = 8'h04;
    localparam logic [7:0] H_CTRL = 8'h08;
    localparam logic [7:0] H_IRQ_STAT = 8'h0C;
    localparam logic [7:0] H_IRQ_MASK = 8'h10;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_PERR = 1;
    typedef enum {SQD_IDLE, SQD_LEAD, SQD_HIGH, SQD_LOW, SQD_TAIL, SQD_GAP} sqd_spi_type;
endpackage

// file: src/sqd_link_if.sv
interface sqd_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic arm_enable_input;
    logic safing_watchdog_input;
    logic reset_n;
    modport device (input sclk, input cs_n, input mosi, output miso, input arm_enable_input,
        input safing_watchdog_input, input reset_n);
    modport host (output sclk, output cs_n, output mosi, input miso, output arm_enable_input,
        output safing_watchdog_input, output reset_n);
endinterface

// file: src/sqd_device.sv
module sqd_device (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    sqd_link_if.device LINK,
    input wire logic [sqd_pkg::NUM_CH-1:0] OVER_TEMP,
    output logic [sqd_pkg::NUM_CH-1:0] HIGH_SIDE_SWITCH,
    output logic [sqd_pkg::NUM_CH-1:0] LOW_SIDE_SWITCH,
    output logic [sqd_pkg::NUM_CH-1:0] HS_DEPLOY_LEVEL,
    output logic [sqd_pkg::NUM_CH-1:0] LS_DEPLOY_LEVEL,
    output logic HS_HIGH_LIMIT
);
    import sqd_pkg::*;
    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int SW = 6 + NUM_CH;
    // idle link in reset: select high, device reset held until the pin is seen high
    localparam logic [SW-1:0] SYNC_RST = {6'h10, {NUM_CH{1'b0}}};
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic sclk_s, cs_s, mosi_s, arm_s, safe_s, rstn_s;
    logic [NUM_CH-1:0] hot_s;
    logic sclk_d, cs_d;
    logic rst;
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
        end
        else
        begin
            sync1 <= {LINK.sclk, LINK.cs_n, LINK.mosi, LINK.arm_enable_input,
                LINK.safing_watchdog_input, LINK.reset_n, OVER_TEMP};
            sync2 <= sync1;
        end
    end
    assign {sclk_s, cs_s, mosi_s, arm_s, safe_s, rstn_s, hot_s} = sync2;
    assign rst = SYS_RST | ~rstn_s;
    always_ff @(posedge CLOCK)
    begin
        if (rst)
        begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end
        else
        begin
            sclk_d <= sclk_s;
            cs_d <= cs_s;
        end
    end
    // ****************************************
    // serial slave
    // ****************************************
    logic [FRAME_W-1:0] rx;
    logic [FRAME_W-1:0] tx;
    logic [FRAME_W-1:0] resp;
    logic [4:0] bit_cnt;
    logic frame_end, frame_ok, wr_exec;
    logic [3:0] f_addr;
    logic [7:0] f_data;
    logic [7:0] rdata;
    logic [3:0] last_addr;
    assign frame_end = ~cs_d & cs_s;
    assign frame_ok = frame_end && bit_cnt == FRAME_BITS && ^rx;
    assign f_addr = rx[F_ADDR_LO +: 4];
    assign f_data = rx[F_DATA_LO +: 8];
    assign wr_exec = frame_ok & rx[F_WR];
    always_ff @(posedge CLOCK)
    begin
        if (rst)
        begin
            rx <= '0;
            bit_cnt <= '0;
        end
        else if (cs_d & ~cs_s)
            bit_cnt <= '0;
        else if (~cs_s & sclk_s & ~sclk_d)
        begin
            rx <= {rx[FRAME_W-2:0], mosi_s};
            if (bit_cnt != 5'h1F)
                bit_cnt <= bit_cnt + 5'h01;
        end
    end
    // answer is the register named by the previous good frame
    always_ff @(posedge CLOCK)
    begin
        if (rst)
            tx <= '0;
        else if (cs_d & ~cs_s)
            tx <= resp;
        else if (~cs_s & ~sclk_s & sclk_d)
            tx <= {tx[FRAME_W-2:0], 1'b0};
    end
    assign LINK.miso = tx[FRAME_W-1];
    always_ff @(posedge CLOCK)
    begin
        if (rst)
            last_addr <= A_STATUS;
        else if (frame_ok)
            last_addr <= f_addr;
    end
    always_comb
    begin
        resp = {1'b0, last_addr, rdata, 3'b000};
        resp[0] = ~^resp;
    end
    // ****************************************
    // configuration registers
    // ****************************************
    logic [7:0] cfg;
    logic key_ok, perr, allow;
    logic [7:0] ontime [NUM_CH];
    always_ff @(posedge CLOCK)
    begin
        if (rst)
            cfg <= CFG_RST;
        else if (wr_exec && f_addr == A_CFG)
            cfg <= f_data;
    end
    always_ff @(posedge CLOCK)
    begin
        if (rst)
            key_ok <= 1'b0;
        else if (wr_exec && f_addr == A_KEY)
            key_ok <= f_data == ARM_KEY;
    end
    always_ff @(posedge CLOCK)
    begin
        if (rst)
            perr <= 1'b0;
        else if (frame_end && !frame_ok)
            perr <= 1'b1;
        else if (wr_exec && f_addr == A_STATUS && f_data[0])
            perr <= 1'b0;
    end
    always_ff @(posedge CLOCK)
    begin
        if (rst)
            ontime <= '{default: ONTIME_RST};
        else if (wr_exec && f_addr[3])
            ontime[f_addr[2:0]] <= f_data;
    end
    assign allow = key_ok & arm_s & ~safe_s;
    assign HS_HIGH_LIMIT = cfg[CFG_HS_HIGH];
    // ****************************************
    // on-time prescaler, one step ~32 us
    // ****************************************
    logic [11:0] step_cnt;
    logic tick;
    assign tick = step_cnt == 12'(STEP_CYC - 1);
    always_ff @(posedge CLOCK)
    begin
        if (rst | tick)
            step_cnt <= '0;
        else
            step_cnt <= step_cnt + 12'h001;
    end
    // ****************************************
    // per-channel deploy control
    // ****************************************
    logic [NUM_CH-1:0] hs, ls, ls_wait, expired, thermal;
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++)
        begin : g_ch
            logic [7:0] fire_cnt;
            logic [11:0] dly;
            logic stop;
            // shared tick: fire time may run up to one step long
            assign stop = hs[i] & (hot_s[i] | (tick && fire_cnt == ontime[i]));
            always_ff @(posedge CLOCK)
            begin
                if (rst | ~allow)
                    hs[i] <= 1'b0;
                else if (stop)
                    hs[i] <= 1'b0;
                else if (wr_exec && f_addr == A_HS_ON && f_data[i])
                    hs[i] <= 1'b1;
            end
            always_ff @(posedge CLOCK)
            begin
                if (rst | ~hs[i])
                    fire_cnt <= '0;
                else if (tick)
                    fire_cnt <= fire_cnt + 8'h01;
            end
            always_ff @(posedge CLOCK)
            begin
                if (rst)
                begin
                    expired[i] <= 1'b0;
                    thermal[i] <= 1'b0;
                end
                else if (stop)
                begin
                    expired[i] <= ~hot_s[i];
                    thermal[i] <= hot_s[i];
                end
                else if (wr_exec && f_addr == A_HS_ON && f_data[i])
                begin
                    expired[i] <= 1'b0;
                    thermal[i] <= 1'b0;
                end
            end
            always_ff @(posedge CLOCK)
            begin
                if (rst | ~ls[i])
                    ls_wait[i] <= 1'b0;
                else if (stop && cfg[CFG_LS_HW])
                    ls_wait[i] <= 1'b1;
            end
            always_ff @(posedge CLOCK)
            begin
                if (rst | ~ls_wait[i])
                    dly <= '0;
                else
                    dly <= dly + 12'h001;
            end
            always_ff @(posedge CLOCK)
            begin
                if (rst | ~allow)
                    ls[i] <= 1'b0;
                else if (ls_wait[i] && dly == 12'(LS_OFF_CYC - 1))
                    ls[i] <= 1'b0;
                else if (wr_exec && f_addr == A_LS_OFF && f_data[i])
                    ls[i] <= 1'b0;
                else if (wr_exec && f_addr == A_LS_ON && f_data[i])
                    ls[i] <= 1'b1;
            end
        end
    endgenerate
    assign HIGH_SIDE_SWITCH = hs;
    assign LOW_SIDE_SWITCH = ls;
    // diagnostic level whenever not firing; low side limit is fixed
    assign HS_DEPLOY_LEVEL = hs;
    assign LS_DEPLOY_LEVEL = ls;
    // ****************************************
    // read mux
    // ****************************************
    always_comb
    begin
        case (last_addr)
            A_CFG: rdata = cfg;
            A_KEY: rdata = {7'h00, key_ok};
            A_HS_ON: rdata = hs;
            A_LS_ON: rdata = ls;
            A_STATUS: rdata = {4'h0, safe_s, arm_s, allow, perr};
            A_EXPIRED: rdata = expired;
            A_THERMAL: rdata = thermal;
            default: rdata = last_addr[3] ? ontime[last_addr[2:0]] : 8'h00;
        endcase
    end
endmodule

// file: src/sqd_host.sv
module sqd_host #(
    parameter int HALF = sqd_pkg::SCLK_HALF_CYC
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    sqd_link_if.host LINK
);
    import sqd_pkg::*;
    if (HALF < 4 || HALF > 255)
    begin : g_bad_half
        $error("HALF must be 4..255");
    end
    // ****************************************
    // apb slave, zero wait
    // ****************************************
    sqd_spi_type state;
    logic wr_acc, rd_setup, mapped, start;
    logic [12:0] cmd;
    logic [15:0] rx;
    logic [2:0] ctrl;
    logic [1:0] irq_stat, irq_mask, ev;
    assign mapped = PADDR == H_CMD || PADDR == H_RESP || PADDR == H_CTRL || PADDR == H_IRQ_STAT
        || PADDR == H_IRQ_MASK;
    assign wr_acc = PSEL & PENABLE & PWRITE & mapped;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign start = wr_acc && PADDR == H_CMD && state == SQD_IDLE;
    assign PREADY = 1'b1;
    // busy refusal shows as an error so software cannot lose a command
    assign PSLVERR = PSEL & PENABLE & (~mapped | (PWRITE && PADDR == H_CMD && state != SQD_IDLE));
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            PRDATA <= '0;
        else if (rd_setup)
        begin
            case (PADDR)
                H_CMD: PRDATA <= {19'h0, cmd};
                H_RESP: PRDATA <= {15'h0, state != SQD_IDLE, rx};
                H_CTRL: PRDATA <= {29'h0, ctrl};
                H_IRQ_STAT: PRDATA <= {30'h0, irq_stat};
                H_IRQ_MASK: PRDATA <= {30'h0, irq_mask};
                default: PRDATA <= '0;
            endcase
        end
    end
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            cmd <= '0;
        else if (start)
            cmd <= PWDATA[12:0];
    end
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            ctrl <= '0;
        else if (wr_acc && PADDR == H_CTRL)
            ctrl <= PWDATA[2:0];
    end
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            irq_mask <= '0;
        else if (wr_acc && PADDR == H_IRQ_MASK)
            irq_mask <= PWDATA[1:0];
    end
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            irq_stat <= '0;
        else if (wr_acc && PADDR == H_IRQ_STAT)
            irq_stat <= (irq_stat & ~PWDATA[1:0]) | ev;
        else
            irq_stat <= irq_stat | ev;
    end
    assign IRQ = |(irq_stat & irq_mask);
    assign LINK.arm_enable_input = ctrl[0];
    assign LINK.safing_watchdog_input = ctrl[1];
    assign LINK.reset_n = ctrl[2];
    // ****************************************
    // spi master, mode 0, sample at falling edge
    // ****************************************
    logic miso1, miso_s;
    logic [7:0] cnt;
    logic [3:0] nbit;
    logic [15:0] tx;
    logic last;
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            miso1 <= 1'b0;
            miso_s <= 1'b0;
        end
        else
        begin
            miso1 <= LINK.miso;
            miso_s <= miso1;
        end
    end
    assign last = cnt == 8'(HALF - 1);
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST || state == SQD_IDLE || last)
            cnt <= '0;
        else
            cnt <= cnt + 8'h01;
    end
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            state <= SQD_IDLE;
            LINK.cs_n <= 1'b1;
            LINK.sclk <= 1'b0;
            tx <= '0;
            rx <= '0;
            nbit <= '0;
            ev <= '0;
        end
        else
        begin
            ev <= '0;
            case (state)
                SQD_IDLE:
                    if (start)
                    begin
                        tx <= {PWDATA[12:0], 2'b00, ~^PWDATA[12:0]};
                        LINK.cs_n <= 1'b0;
                        nbit <= '0;
                        state <= SQD_LEAD;
                    end
                SQD_LEAD, SQD_LOW:
                    if (last)
                    begin
                        LINK.sclk <= 1'b1;
                        state <= SQD_HIGH;
                    end
                SQD_HIGH:
                    if (last)
                    begin
                        LINK.sclk <= 1'b0;
                        rx <= {rx[14:0], miso_s};
                        tx <= {tx[14:0], 1'b0};
                        nbit <= nbit + 4'h1;
                        state <= nbit == 4'hF ? SQD_TAIL : SQD_LOW;
                    end
                SQD_TAIL:
                    if (last)
                    begin
                        LINK.cs_n <= 1'b1;
                        ev[IRQ_DONE] <= 1'b1;
                        ev[IRQ_PERR] <= ~^rx;
                        state <= SQD_GAP;
                    end
                SQD_GAP:
                    if (last)
                        state <= SQD_IDLE;
                default:
                    state <= SQD_IDLE;
            endcase
        end
    end
    assign LINK.mosi = tx[15];
endmodule

// file: sim/sqd_link_props.sv
module sqd_link_props (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic arm_enable_input,
    input wire logic safing_watchdog_input,
    input wire logic reset_n,
    input wire logic [sqd_pkg::NUM_CH-1:0] OVER_TEMP,
    input wire logic [sqd_pkg::NUM_CH-1:0] HIGH_SIDE_SWITCH,
    input wire logic [sqd_pkg::NUM_CH-1:0] LOW_SIDE_SWITCH,
    input wire logic [sqd_pkg::NUM_CH-1:0] HS_DEPLOY_LEVEL,
    input wire logic [sqd_pkg::NUM_CH-1:0] LS_DEPLOY_LEVEL,
    input wire logic HS_HIGH_LIMIT
);
    timeunit 1ns;
    timeprecision 100ps;
    import sqd_pkg::*;
    logic prev_sclk;
    logic [3:0] since_cs;
    logic [4:0] bit_cnt;
    logic [FRAME_W-1:0] shift;
    // ****************************************
    // helpers
    // ****************************************
    always_ff @(posedge CLOCK)
    begin
        prev_sclk <= sclk;
    end
    // saturates so a long idle gap never wraps back into the window
    always_ff @(posedge CLOCK)
    begin
        if (!cs_n)
            since_cs <= 4'h0;
        else if (since_cs != 4'hF)
            since_cs <= since_cs + 4'h1;
    end
    always_ff @(posedge CLOCK)
    begin
        if (cs_n)
            bit_cnt <= 5'h00;
        else if (sclk && !prev_sclk)
            bit_cnt <= bit_cnt + 5'h01;
    end
    always_ff @(posedge CLOCK)
    begin
        if (sclk && !prev_sclk)
            shift <= {shift[FRAME_W-2:0], mosi};
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    a_arm_gates: assert property (!arm_enable_input [*8] |-> HIGH_SIDE_SWITCH == '0 && LOW_SIDE_SWITCH == '0)
        else $error("switch on with arm input low");
    a_safing_gates: assert property (safing_watchdog_input [*8] |-> (HIGH_SIDE_SWITCH | LOW_SIDE_SWITCH) == '0)
        else $error("switch on with safing input high");
    a_devreset_off: assert property (!reset_n [*8] |-> HIGH_SIDE_SWITCH == '0 && LOW_SIDE_SWITCH == '0)
        else $error("switch on during device reset");
    a_reset_diag: assert property ($fell(SYS_RST) |-> HS_DEPLOY_LEVEL == '0 && LS_DEPLOY_LEVEL == '0 && !HS_HIGH_LIMIT)
        else $error("deploy level after reset");
    a_level_follows: assert property (HS_DEPLOY_LEVEL == HIGH_SIDE_SWITCH && LS_DEPLOY_LEVEL == LOW_SIDE_SWITCH)
        else $error("current level not tied to switch");
    a_turn_on_cmd: assert property (
        (|(HIGH_SIDE_SWITCH & ~$past(HIGH_SIDE_SWITCH)) || |(LOW_SIDE_SWITCH & ~$past(LOW_SIDE_SWITCH)))
        |-> cs_n && since_cs >= 4'h1 && since_cs <= 4'hC)
        else $error("switch turned on outside frame end");
    a_thermal_kill: assert property (
        (OVER_TEMP != '0 && $stable(OVER_TEMP)) [*6] |-> (HIGH_SIDE_SWITCH & OVER_TEMP) == '0)
        else $error("hot channel still on");
    a_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("link clock moves outside frame");
    a_frame_bits: assert property ($rose(cs_n) |-> bit_cnt == FRAME_BITS)
        else $error("frame bit count");
    a_frame_parity: assert property ($rose(cs_n) |-> ^shift)
        else $error("frame parity not odd");
endmodule

// file: sim/squib_deploy_control_test.sv
module squib_deploy_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sqd_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, over_temp = 8'h00, v;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, hs_lim, lim2, serr;
    logic [15:0] r2;
    logic [NUM_CH-1:0] hs, ls, hs_lvl, ls_lvl;
    int err_count = 0, n_checks = 0, cyc = 0, n, m;
    sqd_link_if link();
    sqd_link_if link2();
    always #12.5 clk = ~clk;
    sqd_host sqd_host_i (.CLOCK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .LINK(link));
    sqd_device sqd_device_i (.CLOCK(clk), .SYS_RST(sys_rst), .LINK(link), .OVER_TEMP(over_temp),
        .HIGH_SIDE_SWITCH(hs), .LOW_SIDE_SWITCH(ls), .HS_DEPLOY_LEVEL(hs_lvl), .LS_DEPLOY_LEVEL(ls_lvl),
        .HS_HIGH_LIMIT(hs_lim));
    // second device faces a bench driver that can break the frame rules
    sqd_device sqd_device_i2 (.CLOCK(clk), .SYS_RST(sys_rst), .LINK(link2), .OVER_TEMP(8'h00),
        .HIGH_SIDE_SWITCH(), .LOW_SIDE_SWITCH(), .HS_DEPLOY_LEVEL(), .LS_DEPLOY_LEVEL(), .HS_HIGH_LIMIT(lim2));
    sqd_link_props sqd_link_props_i (.CLOCK(clk), .SYS_RST(sys_rst), .sclk(link.sclk), .cs_n(link.cs_n),
        .mosi(link.mosi), .arm_enable_input(link.arm_enable_input), .safing_watchdog_input(link.safing_watchdog_input),
        .reset_n(link.reset_n), .OVER_TEMP(over_temp), .HIGH_SIDE_SWITCH(hs), .LOW_SIDE_SWITCH(ls),
        .HS_DEPLOY_LEVEL(hs_lvl), .LS_DEPLOY_LEVEL(ls_lvl), .HS_HIGH_LIMIT(hs_lim));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // starts on an edge so a release and the next setup never share a time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic dev(input logic w, input logic [3:0] a, input logic [7:0] d);
        int t;
        apb(1'b1, H_CMD, {19'h0_0000, w, a, d});
        t = 0;
        do
        begin
            apb(1'b0, H_RESP, 32'h0000_0000);
            t++;
        end
        while (rd[16] !== 1'b0 && t < 400);
        chk("link busy", 32'h0, 32'(rd[16]));
        repeat (6) @(posedge clk);
    endtask
    // reply is one frame late, so a read costs two frames
    task automatic devrd(input logic [3:0] a);
        dev(1'b0, a, 8'h00);
        dev(1'b0, a, 8'h00);
        chk("reply parity", 32'h1, 32'(^rd[15:0]));
        chk("reply addr", 32'(a), 32'(rd[14:11]));
        v = rd[10:3];
    endtask
    task automatic wait_low(input int ch, input logic side, input int lim);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((side ? ls[ch] : hs[ch]) !== 1'b0 && n < lim);
    endtask
    task automatic frame2(input logic [15:0] f);
        @(posedge clk);
        link2.cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            link2.mosi <= f[i];
            repeat (4) @(posedge clk);
            link2.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            r2 = {r2[14:0], link2.miso};
            link2.sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        link2.cs_n <= 1'b1;
        link2.mosi <= ~f[0];
        repeat (8) @(posedge clk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        chk("reset levels", 32'h0, 32'({hs_lvl, ls_lvl}));
        chk("hs limit", 32'h0, 32'(hs_lim));
        apb(1'b1, H_CTRL, 32'h0000_0005);
        repeat (8) @(posedge clk);
        devrd(A_CFG);
        chk("cfg reset", 32'(CFG_RST), 32'(v));
        dev(1'b1, A_HS_ON, 8'hFF);
        dev(1'b1, A_LS_ON, 8'hFF);
        chk("no key", 32'h0, 32'({hs, ls}));
        dev(1'b1, A_CFG, 8'h03);
        chk("limit high", 32'h1, 32'(hs_lim));
    endtask
    task automatic t_hw_fire;
        dev(1'b1, A_ONTIME0, 8'h01);
        dev(1'b1, A_ONTIME0 + 4'h1, 8'h02);
        dev(1'b1, A_KEY, ARM_KEY);
        devrd(A_STATUS);
        chk("status", 32'h6, 32'(v[3:0]));
        dev(1'b1, A_LS_ON, 8'h03);
        dev(1'b1, A_HS_ON, 8'h03);
        chk("fire on", 32'h0303, 32'({hs, ls}));
        wait_low(0, 1'b0, 2 * STEP_CYC + 8);
        chk("hs0 time", 32'h1, 32'(n >= STEP_CYC - 64 && n < 2 * STEP_CYC));
        chk("ls0 held", 32'h1, 32'(ls[0]));
        m = n;
        wait_low(1, 1'b0, 3 * STEP_CYC);
        chk("hs1 time", 32'h1, 32'(m + n >= 2 * STEP_CYC - 64 && m + n <= 3 * STEP_CYC));
        chk("ls1 held", 32'h1, 32'(ls[1]));
        m = n;
        wait_low(0, 1'b1, LS_OFF_CYC);
        chk("ls0 delay", 32'h1, 32'(m + n >= LS_OFF_CYC - 4 && m + n <= LS_OFF_CYC + 4));
        wait_low(1, 1'b1, LS_OFF_CYC + 8);
        devrd(A_EXPIRED);
        chk("expired", 32'h3, 32'(v));
    endtask
    task automatic t_sw_hold;
        dev(1'b1, A_CFG, 8'h00);
        chk("limit low", 32'h0, 32'(hs_lim));
        dev(1'b1, A_LS_ON, 8'h04);
        dev(1'b1, A_HS_ON, 8'h04);
        wait_low(2, 1'b0, STEP_CYC + 8);
        repeat (LS_OFF_CYC + 100) @(negedge clk);
        chk("ls2 held", 32'h1, 32'(ls[2]));
        dev(1'b1, A_LS_OFF, 8'h04);
        chk("ls2 off", 32'h0, 32'(ls[2]));
        dev(1'b1, A_CFG, 8'h02);
    endtask
    task automatic t_allow;
        logic [31:0] ctl [2] = '{32'h0000_0004, 32'h0000_0007};
        dev(1'b1, A_ONTIME0 + 4'h3, 8'hFF);
        foreach (ctl[i])
        begin
            dev(1'b1, A_LS_ON, 8'h08);
            chk("ls alone", 32'h1, 32'({hs[3], ls[3]}));
            dev(1'b1, A_HS_ON, 8'h08);
            apb(1'b1, H_CTRL, ctl[i]);
            wait_low(3, 1'b0, 10);
            chk("allow drop", 32'h0, 32'({hs[3], ls[3]}));
            apb(1'b1, H_CTRL, 32'h0000_0005);
        end
    endtask
    task automatic t_thermal;
        dev(1'b1, A_ONTIME0 + 4'h4, 8'hFF);
        dev(1'b1, A_LS_ON, 8'h10);
        dev(1'b1, A_HS_ON, 8'h10);
        over_temp <= 8'h10;
        wait_low(4, 1'b0, 10);
        chk("thermal hs", 32'h0, 32'(hs[4]));
        chk("thermal ls", 32'h1, 32'(ls[4]));
        devrd(A_THERMAL);
        chk("thermal flag", 32'h10, 32'(v));
        over_temp <= 8'h00;
        wait_low(4, 1'b1, LS_OFF_CYC + 8);
        chk("thermal ls off", 32'h0, 32'(ls[4]));
    endtask
    task automatic t_irq;
        apb(1'b1, H_IRQ_MASK, 32'h0000_0000);
        @(negedge clk);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, H_IRQ_MASK, 32'h0000_0001);
        @(negedge clk);
        chk("irq raised", 32'h1, 32'(irq));
        apb(1'b1, H_IRQ_STAT, 32'h0000_0001);
        @(negedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b0, H_IRQ_STAT, 32'h0000_0000);
        chk("irq status", 32'h0, rd);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped err", 32'h1, 32'(serr));
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic t_parity;
        logic [14:0] f = {1'b1, A_CFG, 8'h01, 2'b00};
        frame2({f, ^f});
        chk("bad frame", 32'h0, 32'(lim2));
        frame2({f, ~^f});
        chk("good frame", 32'h1, 32'(lim2));
        f = {1'b0, A_STATUS, 8'h00, 2'b00};
        frame2({f, ~^f});
        frame2({f, ~^f});
        chk("parity flag", 32'h1, 32'(r2[3]));
        chk("reply2 parity", 32'h1, 32'(^r2));
    endtask
    // ****************************************
    // main
    // ****************************************
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_count++;
            end_of_test();
        end
    end
    initial
    begin
        link2.sclk <= 1'b0;
        link2.cs_n <= 1'b1;
        link2.mosi <= 1'b0;
        link2.arm_enable_input <= 1'b1;
        link2.safing_watchdog_input <= 1'b0;
        link2.reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_hw_fire();
        t_sw_hold();
        t_allow();
        t_thermal();
        t_irq();
        t_parity();
        end_of_test();
    end
endmodule
